/* File: common/hub_status_map.vh */
// Register offsets, field positions and reset values of the host status bank
`ifndef HUB_STATUS_MAP_VH
`define HUB_STATUS_MAP_VH

`define HOST_STATUS_ADDR      8'h35
`define INTERRUPT_CAUSE_ADDR  8'h36
`define BOOT_STATUS_ADDR      8'h37
`define PENDING_COUNT_LO_ADDR 8'h38
`define PENDING_COUNT_HI_ADDR 8'h39
`define PARAM_ACK_CODE_ADDR   8'h3a
`define PARAM_WINDOW_FIRST    8'h3b
`define PARAM_WINDOW_LAST     8'h4a
`define GP_READBACK_FIRST     8'h4b
`define GP_READBACK_LAST      8'h4f

`define PARAM_WINDOW_DEPTH    16
`define GP_READBACK_DEPTH     5

// Host status fields
`define HS_ALGO_MSB           7
`define HS_ALGO_LSB           5
`define HS_GEN_MSB            4
`define HS_GEN_LSB            2
`define HS_STANDBY_BIT        1
`define HS_RESET_SEEN_BIT     0

// Interrupt cause bit positions
`define IC_HOST_IRQ_BIT       0
`define IC_WAKE_WMARK_BIT     1
`define IC_WAKE_LATENCY_BIT   2
`define IC_WAKE_IMMED_BIT     3
`define IC_NWAKE_WMARK_BIT    4
`define IC_NWAKE_LATENCY_BIT  5
`define IC_NWAKE_IMMED_BIT    6

`define FUSION_ALGO_CODE_RST  3'h0
`define IFACE_GEN_NEWER       3'h1
`define IFACE_GEN_OLDER       3'h0
`define PARAM_ACK_UNSUPPORTED 8'h80
`define PARAM_ACK_RST         8'h00
`define PENDING_COUNT_RST     16'h0000

`endif

/* File: rtl/host_irq_ctrl.v */
// Host interrupt line control: raise, acknowledge on drain, re-raise
`timescale 1ns/1ps
module host_irq_ctrl
(
    input  wire        mclk,          // Device clock
    input  wire        srst,          // Synchronous reset, active high
    input  wire        irqRequest,    // Firmware/FIFO wants the host interrupted
    input  wire        irqMasked,     // Interrupt configuration blocks the line
    input  wire        allBytesRead,  // Host drained the announced bytes
    output reg         hostIrq_r,     // Host interrupt line level
    output wire        refreshReq     // Refresh count just before raising
);

    wire raise = irqRequest & ~irqMasked & ~hostIrq_r;

    // Count update happens in the same cycle the line goes high
    assign refreshReq = raise;

    always @(posedge mclk)
    begin
        if (srst)
            hostIrq_r <= 1'b0;
        else if (irqMasked)
            hostIrq_r <= 1'b0;
        else if (raise)
            hostIrq_r <= 1'b1;
        else if (allBytesRead)
            hostIrq_r <= 1'b0;
    end

endmodule

/* File: rtl/hub_host_status_registers.v */
// Read-only host status register bank of the sensor hub
`timescale 1ns/1ps
`include "hub_status_map.vh"

// Operation
// - Host status: algo, generation, standby, reset
// - Generation field one newer, zero older
// - Standby ack only after request took effect
// - Reset-seen set after power-on or requested reset
// - Interrupt cause readable by polling, bit7 reserved
// - Cause bit0 mirrors host interrupt line
// - Watermark flags on bits 1 and 4
// - Latency flags on bits 2 and 5
// - Immediate flags on bits 3 and 6
// - Boot status, upper three bits zero
// - Count is 16 bits over two bytes
// - Count spans smallest event to total capacity
// - Count refreshed before interrupt or on request
// - Interrupt drops after announced bytes read
// - New data update count, reassert interrupt
// - Host polls ack until match or error
// - Unsupported page or parameter acks 0x80
// - Sixteen parameter read bytes at 0x3b
// - Five firmware-written bytes, host read-only
module hub_host_status_registers
(
    input  wire        mclk,           // Device clock, 25 MHz
    input  wire        srst,           // Synchronous reset, active high
    // Host register port, byte wide
    input  wire [7:0]  hostAddr,       // Register address from host bus
    input  wire        hostRead,       // One-cycle read strobe
    input  wire        hostWrite,      // One-cycle write strobe
    input  wire [7:0]  hostWdata,      // Write data (ignored by this bank)
    output reg  [7:0]  hostRdata_r,    // Read data, valid the cycle after hostRead
    // Host control bits from the host interface control register
    input  wire        standbyReq,     // Standby request bit as written by host
    input  wire        refreshCountReq,// Refresh-count request bit as written
    input  wire        wakeIrqDisable, // Wakeup FIFO interrupt disable
    // Firmware side
    input  wire        standbyEntered, // Firmware: standby actually taken effect
    input  wire        resetReqDone,   // Pulse: requested reset finished
    input  wire [2:0]  fusionAlgoCode, // Algorithm identifier
    input  wire        ifaceNewer,     // One selects newer interface generation
    input  wire [4:0]  bootFlags,      // No-mem, halted, load err, load done, detected
    input  wire        paramAckWrite,  // Pulse: load acknowledge code
    input  wire [7:0]  paramAckCode,   // Requested code echo
    input  wire        paramUnsupported,// Page or parameter not supported
    input  wire        paramWinWrite,  // Write one parameter window byte
    input  wire [3:0]  paramWinIndex,  // Byte index within window
    input  wire [7:0]  paramWinData,   // Byte value
    input  wire        gpWrite,        // Firmware write of a general-purpose byte
    input  wire [2:0]  gpIndex,        // Byte index 0..4
    input  wire [7:0]  gpData,         // Byte value
    // FIFO side
    input  wire [15:0] fifoLevel,      // Live pending byte total
    input  wire        irqRequest,     // Interrupt condition present
    input  wire [5:0]  causeEvents,    // Pulses: nimm,nlat,nwm,wimm,wlat,wwm
    input  wire        allBytesRead,   // Host drained the announced bytes
    output reg         hostIrqPin_r,   // Host interrupt output
    output reg  [15:0] pendingCount_r  // Announced count toward FIFO read logic
);

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    reg  [7:0]  paramWin [0:`PARAM_WINDOW_DEPTH-1];
    reg  [7:0]  gpBytes  [0:`GP_READBACK_DEPTH-1];
    reg         resetSeen_r;
    reg         standbyAck_r;
    reg  [5:0]  cause_r;
    reg  [7:0]  ackCode_r;
    reg  [7:0]  rdataNxt;
    wire        hostIrq;
    wire        refreshIrq;
    wire [15:0] countVis;
    wire [15:0] countHeld;
    wire [7:0]  winOff = hostAddr - `PARAM_WINDOW_FIRST;
    wire [7:0]  gpOff  = hostAddr - `GP_READBACK_FIRST;
    integer     i;

    function inRange;
        input [7:0] a;
        input [7:0] lo;
        input [7:0] hi;
        begin
            inRange = (a >= lo) && (a <= hi);
        end
    endfunction

    //--------------------------------------------------------------------
    // Interrupt and count
    //--------------------------------------------------------------------
    host_irq_ctrl host_irq_ctrl_inst
    (
        .mclk         (mclk),
        .srst         (srst),
        .irqRequest   (irqRequest),
        .irqMasked    (wakeIrqDisable),
        .allBytesRead (allBytesRead),
        .hostIrq_r    (hostIrq),
        .refreshReq   (refreshIrq)
    );

    // Level-held request bit: refresh each cycle it stays set
    pending_count_latch pending_count_latch_inst
    (
        .mclk        (mclk),
        .srst        (srst),
        .fifoLevel   (fifoLevel),
        .refreshNow  (refreshIrq | refreshCountReq),
        .lowByteRead (hostRead && hostAddr == `PENDING_COUNT_LO_ADDR),
        .countVis_r  (countVis),
        .countHeld_r (countHeld)
    );

    //--------------------------------------------------------------------
    // Status flags
    //--------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (srst)
        begin
            resetSeen_r  <= 1'b1;
            standbyAck_r <= 1'b0;
            cause_r      <= 6'h00;
            ackCode_r    <= `PARAM_ACK_RST;
            hostIrqPin_r <= 1'b0;
            pendingCount_r <= `PENDING_COUNT_RST;
        end
        else
        begin
            if (resetReqDone)
                resetSeen_r <= 1'b1;
            standbyAck_r <= standbyReq & standbyEntered;
            // Flags follow the line: a fresh raise or a high line accumulates events, a low line keeps only this cycle's
            if (refreshIrq)
                cause_r <= cause_r | causeEvents;
            else if (!hostIrq)
                cause_r <= causeEvents;
            else
                cause_r <= cause_r | causeEvents;
            if (paramAckWrite)
                ackCode_r <= paramUnsupported ? `PARAM_ACK_UNSUPPORTED : paramAckCode;
            hostIrqPin_r <= hostIrq;
            pendingCount_r <= countVis;
        end
    end

    // Firmware-only write path; the host write strobe reaches nothing here
    always @(posedge mclk)
    begin
        if (srst)
        begin
            for (i = 0; i < `PARAM_WINDOW_DEPTH; i = i + 1)
                paramWin[i] <= 8'h00;
            for (i = 0; i < `GP_READBACK_DEPTH; i = i + 1)
                gpBytes[i] <= 8'h00;
        end
        else
        begin
            if (paramWinWrite)
                paramWin[paramWinIndex] <= paramWinData;
            if (gpWrite && gpIndex < `GP_READBACK_DEPTH)
                gpBytes[gpIndex] <= gpData;
        end
    end

    //--------------------------------------------------------------------
    // Host read decode
    //--------------------------------------------------------------------
    always @*
    begin
        rdataNxt = 8'h00;
        case (hostAddr)
            `HOST_STATUS_ADDR:
                rdataNxt = {fusionAlgoCode,
                            (ifaceNewer ? `IFACE_GEN_NEWER : `IFACE_GEN_OLDER),
                            standbyAck_r, resetSeen_r};
            `INTERRUPT_CAUSE_ADDR:
                rdataNxt = {1'b0, cause_r, hostIrqPin_r};
            `BOOT_STATUS_ADDR:
                rdataNxt = {3'h0, bootFlags};
            `PENDING_COUNT_LO_ADDR:
                rdataNxt = countVis[7:0];
            `PENDING_COUNT_HI_ADDR:
                rdataNxt = countHeld[15:8];
            `PARAM_ACK_CODE_ADDR:
                rdataNxt = ackCode_r;
            default:
            begin
                if (inRange(hostAddr, `PARAM_WINDOW_FIRST, `PARAM_WINDOW_LAST))
                    rdataNxt = paramWin[winOff[3:0]];
                else if (inRange(hostAddr, `GP_READBACK_FIRST, `GP_READBACK_LAST))
                    rdataNxt = gpBytes[gpOff[2:0]];
                else
                    rdataNxt = 8'h00;
            end
        endcase
    end

    always @(posedge mclk)
    begin
        if (srst)
            hostRdata_r <= 8'h00;
        else if (hostRead)
            hostRdata_r <= rdataNxt;
    end

    // Host writes land nowhere in this bank
    wire unusedWrite = hostWrite & (|hostWdata);

endmodule

/* File: rtl/pending_count_latch.v */
// Pending-byte count snapshot with coherent two-byte host view
`timescale 1ns/1ps
module pending_count_latch
(
    input  wire        mclk,          // Device clock
    input  wire        srst,          // Synchronous reset, active high
    input  wire [15:0] fifoLevel,     // Live FIFO byte total from FIFO logic
    input  wire        refreshNow,    // Load live level into visible count
    input  wire        lowByteRead,   // Host reads low byte: freeze pair
    output reg  [15:0] countVis_r,    // Count the device announces
    output reg  [15:0] countHeld_r    // Pair frozen for the host read
);

    always @(posedge mclk)
    begin
        if (srst)
        begin
            countVis_r  <= `PENDING_COUNT_RST;
            countHeld_r <= `PENDING_COUNT_RST;
        end
        else
        begin
            if (refreshNow)
                countVis_r <= fifoLevel;
            // Freeze the value whose low byte goes out now, even if a refresh
            // lands on the same edge, so the later high byte matches it
            if (lowByteRead)
                countHeld_r <= countVis_r;
        end
    end

endmodule

/* File: tb/host_model.sv */
// Host processor model issuing byte reads and writes to the status bank
`timescale 1ns/1ps
module host_model
(
    input  wire       mclk,                   // Device clock
    input  wire [7:0] hostRdata_r,            // Read data
    output reg  [7:0] hostAddr = 8'h00,       // Register address
    output reg        hostRead = 1'b0,        // Read strobe
    output reg        hostWrite = 1'b0,       // Write strobe
    output reg  [7:0] hostWdata = 8'h00,      // Write data
    output reg        standbyReq = 1'b0,      // Standby request bit
    output reg        refreshCountReq = 1'b0  // Refresh-count bit
);
    // Released read address and write data show the inverse so a stale value cannot pass
    task rd(input [7:0] a, output [7:0] d);
        @(posedge mclk);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge mclk);
        hostRead <= 1'b0;
        hostAddr <= ~a;
        @(posedge mclk);
        d = hostRdata_r;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        hostAddr <= a;
        hostWdata <= d;
        hostWrite <= 1'b1;
        @(posedge mclk);
        hostWrite <= 1'b0;
        hostWdata <= ~d;
    endtask
    // Control bits are levels held until the next write
    task ctl(input sb, input rf);
        @(posedge mclk);
        standbyReq <= sb;
        refreshCountReq <= rf;
    endtask
endmodule

/* File: tb/hub_host_status_registers_tb.sv */
// Self-checking bench of the host status register bank
`timescale 1ns/1ps
module hub_host_status_registers_tb;
    reg         mclk = 1'b0, srst = 1'b1, wakeIrqDisable = 1'b0;
    reg         standbyEntered = 1'b0, resetReqDone = 1'b0, ifaceNewer = 1'b1;
    reg  [2:0]  fusionAlgoCode = 3'h5, gpIndex = 3'h0;
    reg  [4:0]  bootFlags = 5'h15;
    reg         paramAckWrite = 1'b0, paramUnsupported = 1'b0, paramWinWrite = 1'b0;
    reg  [7:0]  paramAckCode = 8'h00, paramWinData = 8'h00, gpData = 8'h00, d;
    reg  [3:0]  paramWinIndex = 4'h0;
    reg         gpWrite = 1'b0, irqRequest = 1'b0, allBytesRead = 1'b0;
    reg  [15:0] fifoLevel = 16'h0123;
    reg  [5:0]  causeEvents = 6'h00;
    wire [7:0]  hostAddr, hostWdata, hostRdata_r;
    wire        hostRead, hostWrite, standbyReq, refreshCountReq, hostIrqPin_r;
    wire [15:0] pendingCount_r;
    integer     fails = 0, checks = 0, i;
    hub_host_status_registers hub_host_status_registers_inst (.*);
    host_model host_model_inst (.*);
    initial forever #20 mclk = ~mclk;
    task chk(input [15:0] seen, input [15:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task rdchk(input [7:0] a, input [7:0] e);
        host_model_inst.rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    task waitIrq(input v);
        for (i = 0; i < 20 && hostIrqPin_r !== v; i = i + 1)
            @(posedge mclk);
        chk({15'h0000, hostIrqPin_r}, {15'h0000, v});
    endtask
    initial
    begin
        repeat (4000) @(posedge mclk);
        fails = fails + 1;
        final_report;
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rdchk(8'h35, 8'ha5);
        ifaceNewer <= 1'b0;
        host_model_inst.ctl(1'b1, 1'b0);
        rdchk(8'h35, 8'ha1);
        @(posedge mclk) standbyEntered <= 1'b1;
        rdchk(8'h35, 8'ha3);
        rdchk(8'h37, 8'h15);
        @(posedge mclk) {paramAckWrite, paramAckCode} <= 9'h123;
        @(posedge mclk) paramAckWrite <= 1'b0;
        rdchk(8'h3a, 8'h23);
        @(posedge mclk) {paramAckWrite, paramUnsupported} <= 2'h3;
        @(posedge mclk) paramAckWrite <= 1'b0;
        rdchk(8'h3a, 8'h80);
        for (i = 0; i < 16; i = i + 15)
            @(posedge mclk) {paramWinWrite, paramWinIndex, paramWinData} <= {1'b1, i[3:0], 4'h5, i[3:0]};
        @(posedge mclk) {paramWinWrite, gpWrite, gpIndex, gpData} <= {2'h1, 3'h4, 8'h3c};
        @(posedge mclk) gpWrite <= 1'b0;
        rdchk(8'h3b, 8'h50);
        rdchk(8'h4a, 8'h5f);
        host_model_inst.wr(8'h4f, 8'hc3);
        rdchk(8'h4f, 8'h3c);
        rdchk(8'h50, 8'h00);
        @(posedge mclk) irqRequest <= 1'b1;
        waitIrq(1'b1);
        irqRequest <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
        begin
            @(posedge mclk) causeEvents <= 6'h01 << i;
            @(posedge mclk) causeEvents <= 6'h00;
            rdchk(8'h36, (8'h04 << i) - 8'h01);
        end
        fifoLevel <= 16'h0456;
        rdchk(8'h38, 8'h23);
        host_model_inst.ctl(1'b0, 1'b1);
        repeat (3) @(posedge mclk);
        host_model_inst.ctl(1'b0, 1'b0);
        rdchk(8'h39, 8'h01);
        rdchk(8'h38, 8'h56);
        rdchk(8'h39, 8'h04);
        @(posedge mclk) allBytesRead <= 1'b1;
        @(posedge mclk) allBytesRead <= 1'b0;
        waitIrq(1'b0);
        rdchk(8'h36, 8'h00);
        @(posedge mclk) {irqRequest, fifoLevel} <= 17'h10789;
        waitIrq(1'b1);
        chk(pendingCount_r, 16'h0789);
        @(posedge mclk) wakeIrqDisable <= 1'b1;
        waitIrq(1'b0);
        final_report;
    end
endmodule
bind hub_host_status_registers hub_status_props hub_status_props_inst (.*);

/* File: tb/hub_status_props.sv */
// Checker of the status bank read port and the host interrupt line
`timescale 1ns/1ps
module hub_status_props
(
    input wire        mclk,             // Device clock
    input wire        srst,             // Synchronous reset
    input wire [7:0]  hostAddr,         // Register address
    input wire        hostRead,         // Read strobe
    input wire [7:0]  hostRdata_r,      // Read data
    input wire [2:0]  fusionAlgoCode,   // Algorithm identifier
    input wire        ifaceNewer,       // Interface generation select
    input wire [4:0]  bootFlags,        // Boot flags
    input wire        paramAckWrite,    // Ack load strobe
    input wire        paramUnsupported, // Ack error select
    input wire        irqRequest,       // Interrupt condition
    input wire [15:0] fifoLevel,        // Live byte total
    input wire        allBytesRead,     // Drain done
    input wire        hostIrqPin_r,     // Interrupt output
    input wire [15:0] pendingCount_r    // Announced count
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    function automatic logic rdAt(input logic [7:0] a);
        rdAt = hostRead && hostAddr == a;
    endfunction
    a_unmapped_zero: assert property (hostRead && hostAddr > 8'h4f |=> hostRdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_algo_field: assert property (rdAt(8'h35) |=> hostRdata_r[7:5] == $past(fusionAlgoCode))
        else $error("algorithm field wrong");
    a_gen_field: assert property (rdAt(8'h35) |=> hostRdata_r[4:2] == {2'h0, $past(ifaceNewer)})
        else $error("generation field wrong");
    a_cause_reserved: assert property (rdAt(8'h36) |=> !hostRdata_r[7])
        else $error("reserved cause bit set");
    a_cause_mirror: assert property (rdAt(8'h36) ##1 $stable(hostIrqPin_r)
        |-> hostRdata_r[0] == hostIrqPin_r)
        else $error("cause bit0 differs from line");
    a_boot_field: assert property (rdAt(8'h37) |=> hostRdata_r == {3'h0, $past(bootFlags)})
        else $error("boot status wrong");
    a_ack_error: assert property (paramAckWrite && paramUnsupported ##1 !paramAckWrite
        ##1 rdAt(8'h3a) |=> hostRdata_r == 8'h80)
        else $error("unsupported ack wrong");
    a_drain_drop: assert property (allBytesRead && !irqRequest |-> ##2 !hostIrqPin_r)
        else $error("line not dropped after drain");
    a_raise_count: assert property ($rose(hostIrqPin_r) && $past(fifoLevel) == $past(fifoLevel, 2)
        |-> pendingCount_r == $past(fifoLevel))
        else $error("count not refreshed at raise");
    cover property (rdAt(8'h38) ##[1:4] rdAt(8'h39));
    cover property ($rose(hostIrqPin_r));
    cover property (paramAckWrite && paramUnsupported);
endmodule
